// File: common/swm_defines.svh
// Timing, threshold and count constants for the secondary wake monitor.
// Assumes a 125 MHz ref_clk; all cycle counts derive from it.
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH

`define SWM_CLK_MHZ 125
`define SWM_ARM_NS 500
`define SWM_ARM_CYC ((`SWM_ARM_NS * `SWM_CLK_MHZ + 999) / 1000)
`define SWM_PULSE_NS 1000
`define SWM_PULSE_CYC ((`SWM_PULSE_NS * `SWM_CLK_MHZ) / 1000)
`define SWM_RATE_KHZ 33
`define SWM_RATE_CYC ((`SWM_CLK_MHZ * 1000) / `SWM_RATE_KHZ)
`define SWM_DIS_US 177
`define SWM_DIS_CYC (`SWM_DIS_US * `SWM_CLK_MHZ)
`define SWM_EN_US 57
`define SWM_EN_CYC (`SWM_EN_US * `SWM_CLK_MHZ)
`define SWM_LONG_RUN 63
`define SWM_SHORT_SUM 32
`define SWM_DROOP_NUM 97
`define SWM_DROOP_DEN 100
`define SWM_LEVEL_W 12

`endif

// File: common/swm_pkg.sv
// Types shared by the secondary wake monitor and its period meter.
// Assumes swm_defines.svh is on the include path.
`include "swm_defines.svh"

package swm_pkg;

  typedef logic [`SWM_LEVEL_W-1:0] swm_level_t;

  // One classified switching period, valid for one cycle
  typedef struct packed {
    logic valid;
    logic is_long;
    logic is_short;
  } swm_period_t;

  // Secondary enable pin: open, or pulled low
  typedef enum logic {SWM_SEC_OPEN, SWM_SEC_LOW} swm_sec_state_t;

endpackage

// File: logic/swm_period_meter.sv
// Switching period meter: counts cycles between detect pulses and classifies each period.
// Assumes detect is a one-cycle pulse on ref_clk; clear holds it idle.
`timescale 1ns/10ps
`include "swm_defines.svh"

module swm_period_meter #(
  parameter int CNT_W = 16,
  parameter int DIS_CYC = `SWM_DIS_CYC,
  parameter int EN_CYC = `SWM_EN_CYC
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clear, // Synchronous idle while locked out
  input wire logic detect, // Power-cycle detect pulse
  output swm_pkg::swm_period_t period // Classified period, one-cycle valid
);
  import swm_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic started_r;
  swm_period_t period_nxt;
  wire cnt_full = &cnt_r;

  // Period counter restarts on each detect, saturates when idle
  assign cnt_nxt = detect ? {{(CNT_W-1){1'b0}}, 1'b1} : (cnt_full ? cnt_r : cnt_r + 1'b1);
  assign period_nxt.valid = detect && started_r;
  assign period_nxt.is_long = cnt_r > CNT_W'(DIS_CYC);
  assign period_nxt.is_short = cnt_r < CNT_W'(EN_CYC);

  // Counter and result registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      started_r <= 1'b0;
      period <= '0;
    end
    else if (clear)
    begin
      cnt_r <= '0;
      started_r <= 1'b0;
      period <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      started_r <= started_r | detect;
      period <= period_nxt;
    end
  end

  a_period_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    period.valid |=> !period.valid) else $error("period result longer than one cycle");
  a_period_class: assert property (@(posedge ref_clk) disable iff (!rst_n)
    period.valid |-> !(period.is_long && period.is_short))
    else $error("period both long and short");

endmodule

// File: logic/swm_wake_monitor.sv
// Secondary wake monitor: detects power cycles on the wake line, samples the supply,
// sends wake pulses on a 3% droop, and drives the open-drain secondary enable.
// Assumes wake_above and supply_good are asynchronous comparator outputs and
// vdd_level is a converter word already on ref_clk.
//
// Summary of operation
// - Store the supply level as reference at the end of every detected power cycle.
// - When supply falls to 97% of the reference, switch the wake line to output.
// - Below supply lockout stay fully inactive: no sampling, no signalling.
// - Pull enable low after 63 consecutive periods longer than 177 us.
// - Release enable after 32 cumulative periods shorter than 57 us.
// - Arm detection only after wake stays below threshold more than 500 ns.
// - Armed rise gives one detect pulse: reset oscillator, count cycle, resample.
// - In output mode inject 1 us pulses at 33 kHz until a power cycle is seen.
`timescale 1ns/10ps
`include "swm_defines.svh"

module swm_wake_monitor #(
  parameter int DIS_CYC = `SWM_DIS_CYC,
  parameter int EN_CYC = `SWM_EN_CYC,
  parameter int CYCLE_W = 16
) (
  input wire logic ref_clk, // 125 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wake_above, // Wake comparator, high above detect threshold
  input wire logic supply_good, // Supply above lockout threshold
  input wire swm_pkg::swm_level_t vdd_level, // Present supply level
  output logic wake_drive, // Wake pin output value
  output logic wake_drive_en, // Wake pin output enable
  output logic sec_enable_drive, // Enable pin output value, always low
  output logic sec_enable_drive_en, // Enable pin pulled low when high
  output logic [CYCLE_W-1:0] power_cycle_count // Detected power cycles
);
  import swm_pkg::*;

  localparam int ARM_CYC = `SWM_ARM_CYC;
  localparam int PULSE_CYC = `SWM_PULSE_CYC;
  localparam int RATE_CYC = `SWM_RATE_CYC;
  localparam int ARM_W = $clog2(ARM_CYC + 1);
  localparam int RATE_W = $clog2(RATE_CYC + 1);
  localparam int PROD_W = `SWM_LEVEL_W + 8;

  // Two-stage synchronisers for the comparator pins
  logic wake_m_r, wake_s_r, wake_d_r;
  logic good_m_r, good_s_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_m_r <= 1'b0;
      wake_s_r <= 1'b0;
      good_m_r <= 1'b0;
      good_s_r <= 1'b0;
    end
    else
    begin
      wake_m_r <= wake_above;
      wake_s_r <= wake_m_r;
      good_m_r <= supply_good;
      good_s_r <= good_m_r;
    end
  end

  wire active = good_s_r;

  // Arming: low time counted while the line is not our own drive
  logic [ARM_W-1:0] low_cnt_r, low_cnt_nxt;
  logic armed_r, armed_nxt, detect_r, detect_nxt;
  wire low_seen = !wake_s_r && !wake_drive_en;
  wire low_done = low_cnt_r == ARM_W'(ARM_CYC);
  wire rise = wake_s_r && !wake_d_r && !wake_drive_en;
  assign low_cnt_nxt = !low_seen ? '0 : (low_done ? low_cnt_r : low_cnt_r + 1'b1);
  assign armed_nxt = detect_nxt ? 1'b0 : (armed_r | low_done);
  assign detect_nxt = armed_r && rise;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_d_r <= 1'b0;
      low_cnt_r <= '0;
      armed_r <= 1'b0;
      detect_r <= 1'b0;
    end
    else
    begin
      wake_d_r <= wake_s_r;
      low_cnt_r <= active ? low_cnt_nxt : '0;
      armed_r <= active && armed_nxt;
      detect_r <= active && detect_nxt;
    end
  end

  // Reference sample and power-cycle counter
  swm_level_t ref_r;
  logic ref_valid_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_r <= '0;
      ref_valid_r <= 1'b0;
      power_cycle_count <= '0;
    end
    else if (!active)
      ref_valid_r <= 1'b0;
    else if (detect_r)
    begin
      ref_r <= vdd_level;
      ref_valid_r <= 1'b1;
      power_cycle_count <= power_cycle_count + 1'b1;
    end
  end

  // Droop compare: vdd * 100 <= ref * 97
  wire [PROD_W-1:0] vdd_scaled = PROD_W'(vdd_level) * PROD_W'(`SWM_DROOP_DEN);
  wire [PROD_W-1:0] ref_scaled = PROD_W'(ref_r) * PROD_W'(`SWM_DROOP_NUM);
  wire droop = ref_valid_r && (vdd_scaled <= ref_scaled);

  // Output mode and wake oscillator, reset by each detect
  logic alert_r;
  logic [RATE_W-1:0] osc_r, osc_nxt;
  wire osc_wrap = osc_r == RATE_W'(RATE_CYC - 1);
  assign osc_nxt = (detect_r || !alert_r || osc_wrap) ? '0 : osc_r + 1'b1;
  // Phase zero is the first pulse cycle, so every burst not cut by a detect or lockout is a full PULSE_CYC long
  wire pulse_nxt = alert_r && !detect_r && (osc_r < RATE_W'(PULSE_CYC));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert_r <= 1'b0;
      osc_r <= '0;
      wake_drive <= 1'b0;
      wake_drive_en <= 1'b0;
    end
    else
    begin
      alert_r <= active && !detect_r && (alert_r || droop);
      osc_r <= osc_nxt;
      wake_drive <= active && pulse_nxt;
      wake_drive_en <= active && pulse_nxt;
    end
  end

  // Period classification
  swm_period_t period;
  swm_period_meter #(
    .CNT_W(16),
    .DIS_CYC(DIS_CYC),
    .EN_CYC(EN_CYC)
  ) u_meter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(!active),
    .detect(detect_r),
    .period(period)
  );

  // Secondary enable state machine with its counters
  swm_sec_state_t sec_r, sec_nxt;
  logic [5:0] long_cnt_r, long_cnt_nxt;
  logic [5:0] short_cnt_r, short_cnt_nxt;
  wire long_hit = period.valid && period.is_long;
  wire short_hit = period.valid && period.is_short;
  wire go_low = long_hit && long_cnt_r == 6'(`SWM_LONG_RUN - 1);
  wire go_open = short_hit && short_cnt_r == 6'(`SWM_SHORT_SUM - 1);

  always_comb
  begin
    sec_nxt = sec_r;
    long_cnt_nxt = long_cnt_r;
    short_cnt_nxt = short_cnt_r;
    unique case (sec_r)
      SWM_SEC_OPEN:
      begin
        if (period.valid)
          long_cnt_nxt = long_hit ? long_cnt_r + 6'h01 : 6'h00;
        if (go_low)
        begin
          sec_nxt = SWM_SEC_LOW;
          short_cnt_nxt = 6'h00;
        end
      end
      SWM_SEC_LOW:
      begin
        if (short_hit)
          short_cnt_nxt = short_cnt_r + 6'h01;
        if (go_open)
        begin
          sec_nxt = SWM_SEC_OPEN;
          long_cnt_nxt = 6'h00;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_r <= SWM_SEC_OPEN;
      long_cnt_r <= '0;
      short_cnt_r <= '0;
      sec_enable_drive_en <= 1'b0;
    end
    else if (!active)
    begin
      sec_r <= SWM_SEC_OPEN;
      long_cnt_r <= '0;
      short_cnt_r <= '0;
      sec_enable_drive_en <= 1'b0;
    end
    else
    begin
      sec_r <= sec_nxt;
      long_cnt_r <= long_cnt_nxt;
      short_cnt_r <= short_cnt_nxt;
      sec_enable_drive_en <= sec_nxt == SWM_SEC_LOW;
    end
  end

  // Open-drain pin only ever pulls low
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sec_enable_drive <= 1'b0;
    else
      sec_enable_drive <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pulse_start;
    $rose(wake_drive_en) ##1 !detect_r;
  endsequence

  a_ref_capture: assert property (detect_r |=> ref_r == $past(vdd_level))
    else $error("reference not captured on detect");
  a_droop_alert: assert property (active && droop && !detect_r |=> alert_r)
    else $error("droop did not enter output mode");
  a_lockout_quiet: assert property (!active |=> !wake_drive_en && !sec_enable_drive_en
    && !detect_r)
    else $error("activity during supply lockout");
  a_sec_pull: assert property (active && sec_r == SWM_SEC_OPEN && go_low
    |=> sec_enable_drive_en)
    else $error("enable not pulled after long run");
  a_sec_release: assert property (active && sec_r == SWM_SEC_LOW && go_open
    |=> !sec_enable_drive_en)
    else $error("enable not released after short count");
  a_arm_delay: assert property ($rose(armed_r) |-> $past(low_cnt_r) == ARM_W'(ARM_CYC))
    else $error("armed before low time elapsed");
  a_detect_once: assert property (detect_r |-> $past(armed_r) ##1 !detect_r && !armed_r)
    else $error("detect not a single armed pulse");
  a_pulse_hold: assert property (s_pulse_start |-> wake_drive_en)
    else $error("wake pulse shorter than two cycles");
  a_pulse_width: assert property ($fell(wake_drive_en) && alert_r && !$past(detect_r)
    |-> $past(osc_r) == RATE_W'(PULSE_CYC))
    else $error("wake pulse width wrong");
  a_long_restart: assert property (active && sec_r == SWM_SEC_OPEN && period.valid
    && !period.is_long |=> long_cnt_r == 6'h00)
    else $error("long counter not restarted");

endmodule

// File: testbench/swm_primary_model.sv
// Primary-side controller model: switching pulses seen by the wake comparator.
// Assumes requests change off the falling edge of ref_clk.
`timescale 1ns/10ps
module swm_primary_model (
  input wire logic ref_clk, // Bench clock
  input wire logic req, // Request one switching cycle
  input wire logic [15:0] gap, // Low cycles before the pulse
  input wire logic answer_en, // Answer wake bursts
  input wire logic [3:0] answer_skip, // Bursts ignored before answering
  input wire logic wake_drive, // Device wake output value
  input wire logic wake_drive_en, // Device wake output enable
  output logic wake_above, // Comparator view of the winding
  output logic busy // Cycle in progress
);
  logic level = 1'b0;
  logic prev_en = 1'b0;
  int skip = 0;
  // The comparator also sees the device's own drive
  assign wake_above = level | (wake_drive & wake_drive_en);
  // One cycle: winding low for gap, then a short high pulse
  task automatic cycle();
    busy = 1'b1;
    repeat (gap) @(negedge ref_clk);
    level = 1'b1;
    repeat (8) @(negedge ref_clk);
    level = 1'b0;
    // Busy drops off the rising edge so the bench, which samples on falling edges, never races it
    @(posedge ref_clk);
    busy = 1'b0;
  endtask
  // Switch on request, or once a wake burst ends (slow if skipping)
  initial
  begin
    busy = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (req)
        cycle();
      else if (answer_en && prev_en && !wake_drive_en)
      begin
        if (skip < answer_skip)
          skip++;
        else
          cycle();
      end
      prev_en = wake_drive_en;
    end
  end
endmodule

// File: testbench/swm_wake_monitor_test.sv
// Self-checking bench for the secondary wake monitor.
// Assumes the design files and swm_primary_model are compiled first.
`timescale 1ns/10ps
module swm_wake_monitor_test;
  import swm_pkg::*;
  typedef struct {int gap; int n; int dets;} swm_row_t;
  swm_row_t rows[3] = '{'{320, 3, 3}, '{70, 3, 3}, '{45, 3, 1}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_good = 1'b1;
  logic req = 1'b0;
  logic answer_en = 1'b0;
  logic [15:0] gap = 16'h0001;
  swm_level_t vdd_level = 12'h3E8;
  logic wake_above, busy, wake_drive, wake_drive_en, sec_enable_drive, sec_enable_drive_en;
  logic [15:0] power_cycle_count;
  logic [15:0] c0;
  int n_errors = 0;
  int n_compared = 0;
  int k, k2;
  // Shortened period thresholds keep the run brief
  swm_wake_monitor #(.DIS_CYC(300), .EN_CYC(100)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .wake_above(wake_above), .supply_good(supply_good), .vdd_level(vdd_level),
    .wake_drive(wake_drive), .wake_drive_en(wake_drive_en), .sec_enable_drive(sec_enable_drive),
    .sec_enable_drive_en(sec_enable_drive_en), .power_cycle_count(power_cycle_count));
  swm_primary_model far (.ref_clk(ref_clk), .req(req), .gap(gap), .answer_en(answer_en),
    .answer_skip(4'h1), .wake_drive(wake_drive), .wake_drive_en(wake_drive_en),
    .wake_above(wake_above), .busy(busy));
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // n switching cycles from the model, each followed by a few idle cycles
  task automatic pulses(input int n, input int g);
    repeat (n)
    begin
      gap = 16'(g);
      req = 1'b1;
      @(negedge ref_clk);
      req = 1'b0;
      k = 0;
      while (busy && k < 2000)
      begin
        @(negedge ref_clk);
        k++;
      end
      if (k >= 2000)
        n_errors++;
      repeat (6) @(negedge ref_clk);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog about 30% beyond the expected run length
  initial
  begin
    #800000;
    n_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (5) @(negedge ref_clk);
    chk("drive_en in reset", 16'h0000, {15'h0, wake_drive_en});
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("count after reset", 16'h0000, power_cycle_count);
    $display("test reset done");
    // Rows: gap before each pulse and expected detect count
    foreach (rows[i])
    begin
      repeat (100) @(negedge ref_clk);
      c0 = power_cycle_count;
      pulses(rows[i].n, rows[i].gap);
      chk("detects", c0 + 16'(rows[i].dets), power_cycle_count);
      chk("no drive", 16'h0000, {15'h0, wake_drive_en});
    end
    $display("test rows done");
    // Droop against the stored 1000 reference
    vdd_level = 12'h3CB;
    repeat (20) @(negedge ref_clk);
    chk("drive at 97.1", 16'h0000, {15'h0, wake_drive_en});
    c0 = power_cycle_count;
    answer_en = 1'b1;
    vdd_level = 12'h3CA;
    k = 0;
    while (!wake_drive_en && k < 10)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk("drive at 97", 16'h0001, {15'h0, wake_drive});
    k = 0;
    while (wake_drive_en && k < 200)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk("burst length", 16'h007D, 16'(k));
    k2 = 0;
    while (!wake_drive_en && k2 < 4000)
    begin
      @(negedge ref_clk);
      k2++;
    end
    chk("burst repeat", 16'h0ECB, 16'(k + k2));
    k = 0;
    while (power_cycle_count === c0 && k < 4000)
    begin
      @(negedge ref_clk);
      k++;
    end
    answer_en = 1'b0;
    chk("answer detect", c0 + 16'h0001, power_cycle_count);
    repeat (4) @(negedge ref_clk);
    k2 = 0;
    repeat (4000)
    begin
      @(negedge ref_clk);
      if (wake_drive_en !== 1'b0)
        k2++;
    end
    chk("new reference", 16'h0000, 16'(k2));
    $display("test droop done");
    // Enable output: long runs, restart, cumulative shorts
    // The first pulse after the long idle measures long; the second restarts
    pulses(2, 150);
    pulses(62, 320);
    chk("open after 62", 16'h0000, {15'h0, sec_enable_drive_en});
    pulses(1, 150);
    pulses(62, 320);
    chk("open after restart", 16'h0000, {15'h0, sec_enable_drive_en});
    pulses(1, 320);
    chk("low after 63", 16'h0001, {15'h0, sec_enable_drive_en});
    chk("pin value", 16'h0000, {15'h0, sec_enable_drive});
    pulses(31, 70);
    pulses(1, 150);
    chk("low after 31", 16'h0001, {15'h0, sec_enable_drive_en});
    pulses(1, 70);
    chk("open after 32", 16'h0000, {15'h0, sec_enable_drive_en});
    $display("test enable done");
    // Lockout: no detects and no drive even with a deep droop
    pulses(63, 320);
    chk("low before lockout", 16'h0001, {15'h0, sec_enable_drive_en});
    supply_good = 1'b0;
    repeat (4) @(negedge ref_clk);
    c0 = power_cycle_count;
    vdd_level = 12'h1F4;
    pulses(2, 320);
    chk("count locked", c0, power_cycle_count);
    chk("drive locked", 16'h0000, {15'h0, wake_drive_en});
    chk("enable locked", 16'h0000, {15'h0, sec_enable_drive_en});
    // Back from lockout the old reference must not raise an alert
    supply_good = 1'b1;
    k2 = 0;
    repeat (200)
    begin
      @(negedge ref_clk);
      if (wake_drive_en !== 1'b0)
        k2++;
    end
    chk("no stale reference", 16'h0000, 16'(k2));
    $display("test lockout done");
    print_verdict();
  end
endmodule
